// ### fbs_consts.vh
// constants for the fieldbus selection register bank
// assumes inclusion by bare name from the design files
`ifndef FBS_CONSTS_VH
`define FBS_CONSTS_VH

// object indices and array elements
`define FBS_IDX_BOOT        16'h2084
`define FBS_IDX_PRESENCE    16'h2101
`define FBS_IDX_ACTIVATION  16'h2102
`define FBS_IDX_STATE       16'h2103
`define FBS_IDX_REFUSED     16'h2104
`define FBS_SUB_VAR         8'h00
`define FBS_SUB_COUNT       8'h00
`define FBS_SUB_SWITCHABLE  8'h01
`define FBS_SUB_ACTIVE      8'h02

// physical interface bits
`define FBS_BIT_USB         0
`define FBS_BIT_RS485       1
`define FBS_BIT_RS232       2
`define FBS_BIT_CAN         3
`define FBS_BIT_PLAIN_ETH   4
`define FBS_BIT_RT_ETH      5
`define FBS_BIT_SPI         6
// protocol bits
`define FBS_BIT_MODBUS_SER  16
`define FBS_BIT_MODBUS_TCP  17
`define FBS_BIT_IND_OBJ     18

// reset and fixed values
`define FBS_RST_BOOT        32'h00000000
`define FBS_RST_PRESENCE    32'h00040010
`define FBS_RST_ACTIVATION  32'h00040010
`define FBS_RST_SWITCHABLE  32'h00000000
`define FBS_RST_REFUSED     32'h00000000
`define FBS_STATE_COUNT     8'h02

// timing
`define FBS_MS_NS           1000000
`define FBS_CLK_NS          50
`define FBS_CYC_PER_MS      (`FBS_MS_NS / `FBS_CLK_NS)

`endif

// ### fbs_boot_timer.v
// power-up readiness timer counting whole milliseconds
// assumes one clock, synchronous active-high reset marking power-up
`timescale 1ns/1ns
`include "fbs_consts.vh"

module fbs_boot_timer #(
  parameter CYC_PER_MS = `FBS_CYC_PER_MS
) (
  // clock and reset
  input  wire        i_mclk,
  input  wire        i_reset,
  // delay in milliseconds, live value
  input  wire [31:0] i_delay_ms,
  // readiness
  output reg         o_ready
);

  localparam [31:0] PRE_LAST = CYC_PER_MS - 1;

  reg  [31:0] pre_ff;
  reg  [31:0] ms_ff;
  wire        ms_tick;
  wire        elapsed;

  assign ms_tick = (pre_ff == PRE_LAST);
  // live compare: a write during the wait stretches or ends it
  assign elapsed = (ms_ff >= i_delay_ms);

  always @(posedge i_mclk) begin
    if (i_reset) begin
      pre_ff  <= 32'h00000000;
      ms_ff   <= 32'h00000000;
      o_ready <= 1'b0;
    end else if (!o_ready) begin
      // readiness is sticky until the next power-up
      o_ready <= elapsed;                                 // [R1]
      if (ms_tick) begin
        pre_ff <= 32'h00000000;
        if (ms_ff != 32'hffffffff) begin
          ms_ff <= ms_ff + 32'h00000001;
        end
      end else begin
        pre_ff <= pre_ff + 32'h00000001;
      end
    end
  end

endmodule

// ### fbs_regs.v
// fieldbus selection register bank: boot delay, presence, activation,
// switchable mask, active set and refused-write record
// assumes a simple strobe bus synchronous to i_mclk, no wait states
//
// Operation
// R1 - a writable 32-bit boot delay, reset zero, holds readiness off N ms; code clears it with the timer at reset, so ready comes 2 cycles after reset.
// R2 - read-only 32-bit presence: interfaces in bits 0-15, protocols 16-31.
// R3 - bits 0-6: USB, RS-485, RS-232, CAN, Ethernet, RT Ethernet, SPI.
// R4 - bits 16-18: Modbus serial, Modbus TCP, the object protocol.
// R5 - a writable 32-bit activation word, reset 00040010, switches buses.
// R6 - the activation word uses the presence word's bit layout.
// R7 - only switchable bits change by activation; active set is reported.
// R8 - array element 1 is a read-only switchable mask, reset to zero.
// R9 - array element 2 is the read-only active set, reset to 00040010.
// R10 - array element 0 is a read-only 8-bit count fixed at 02.
// R11 - mask and active set share the presence word's bit layout.
// R12 - unassigned bits read zero in all map words; writes to them drop.
// R13 - a write to a non-switchable bit leaves that fieldbus as it is.
`timescale 1ns/1ns
`include "fbs_consts.vh"

module fbs_regs #(
  parameter [31:0] PRESENCE   = `FBS_RST_PRESENCE,
  parameter [31:0] SWITCHABLE = `FBS_RST_SWITCHABLE,
  parameter        CYC_PER_MS = `FBS_CYC_PER_MS
) (
  // clock and reset
  input  wire        i_mclk,
  input  wire        i_reset,
  // register bus, byte address
  input  wire [25:0] i_addr,
  input  wire [31:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [31:0] o_rdata,
  output reg         o_rvalid,
  // block state
  output reg         o_ready,
  output reg  [31:0] o_fieldbus_enable
);

  // assigned positions of the map
  localparam [31:0] ASSIGNED =
    (32'h1 << `FBS_BIT_USB)        |
    (32'h1 << `FBS_BIT_RS485)      |
    (32'h1 << `FBS_BIT_RS232)      |
    (32'h1 << `FBS_BIT_CAN)        |
    (32'h1 << `FBS_BIT_PLAIN_ETH)  |
    (32'h1 << `FBS_BIT_RT_ETH)     |
    (32'h1 << `FBS_BIT_SPI)        |
    (32'h1 << `FBS_BIT_MODBUS_SER) |
    (32'h1 << `FBS_BIT_MODBUS_TCP) |
    (32'h1 << `FBS_BIT_IND_OBJ);

  // constant words with unassigned bits forced low
  localparam [31:0] PRESENCE_W   = PRESENCE & ASSIGNED;       // [R12]
  localparam [31:0] SWITCHABLE_W = SWITCHABLE & ASSIGNED;     // [R12]

  // element address: object index and array element
  function [23:0] fbs_elem;
    input [15:0] idx;
    input [7:0]  sub;
    begin
      fbs_elem = {idx, sub};
    end
  endfunction

  // word-aligned hit on one element
  function fbs_hit;
    input [25:0] addr;
    input [23:0] elem;
    begin
      fbs_hit = (addr[25:2] == elem) && (addr[1:0] == 2'b00);
    end
  endfunction

  // bits a write may change, all others keep their old value
  function [31:0] fbs_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [31:0] allow;
    begin
      fbs_merge = (old_val & ~allow) | (new_val & allow);
    end
  endfunction

  // decoded selects
  wire sel_boot;
  wire sel_presence;
  wire sel_activation;
  wire sel_count;
  wire sel_switchable;
  wire sel_active;
  wire sel_refused;

  assign sel_boot       = fbs_hit(i_addr,
                            fbs_elem(`FBS_IDX_BOOT, `FBS_SUB_VAR));
  assign sel_presence   = fbs_hit(i_addr,
                            fbs_elem(`FBS_IDX_PRESENCE, `FBS_SUB_VAR));
  assign sel_activation = fbs_hit(i_addr,
                            fbs_elem(`FBS_IDX_ACTIVATION, `FBS_SUB_VAR));
  assign sel_count      = fbs_hit(i_addr,
                            fbs_elem(`FBS_IDX_STATE, `FBS_SUB_COUNT));
  assign sel_switchable = fbs_hit(i_addr,
                            fbs_elem(`FBS_IDX_STATE, `FBS_SUB_SWITCHABLE));
  assign sel_active     = fbs_hit(i_addr,
                            fbs_elem(`FBS_IDX_STATE, `FBS_SUB_ACTIVE));
  assign sel_refused    = fbs_hit(i_addr,
                            fbs_elem(`FBS_IDX_REFUSED, `FBS_SUB_VAR));

  // registers
  reg  [31:0] boot_ready_delay_ms_ff;
  reg  [31:0] fieldbus_activation_ff;
  reg  [31:0] fieldbus_active_set_ff;
  reg  [31:0] fieldbus_refused_ff;
  reg  [31:0] nxt_boot_ready_delay_ms;
  reg  [31:0] nxt_fieldbus_activation;
  reg  [31:0] nxt_fieldbus_refused;
  reg  [31:0] nxt_rdata;
  reg  [31:0] refused_now;
  wire        timer_ready;

  // boot delay
  always @* begin
    nxt_boot_ready_delay_ms = boot_ready_delay_ms_ff;
    if (i_wr && sel_boot) begin
      nxt_boot_ready_delay_ms = i_wdata;                     // [R1]
    end
  end

  // activation word; mask shares the presence layout
  always @* begin
    nxt_fieldbus_activation = fieldbus_activation_ff;
    refused_now             = 32'h00000000;
    if (i_wr && sel_activation) begin
      // same bit positions as presence, dropping unassigned ones
      nxt_fieldbus_activation = fbs_merge(fieldbus_activation_ff,
                                          i_wdata,      // [R11] [R12]
                                          SWITCHABLE_W); // [R6] [R7]
      // attempted changes to locked bits are recorded, not applied
      refused_now = (i_wdata ^ fieldbus_activation_ff)
                    & ~SWITCHABLE_W & ASSIGNED;              // [R13]
    end
  end

  // refused record: write one to clear, a new refusal wins
  always @* begin
    nxt_fieldbus_refused = fieldbus_refused_ff;
    if (i_wr && sel_refused) begin
      nxt_fieldbus_refused = fieldbus_refused_ff & ~i_wdata;
    end
    nxt_fieldbus_refused = nxt_fieldbus_refused | refused_now;
  end

  // read multiplexer, unmapped or misaligned reads give zero
  always @* begin
    nxt_rdata = 32'h00000000;
    if (sel_boot) begin
      nxt_rdata = boot_ready_delay_ms_ff;                    // [R1]
    end else if (sel_presence) begin
      nxt_rdata = PRESENCE_W;   // [R2] [R3] [R4] [R12]
    end else if (sel_activation) begin
      nxt_rdata = fieldbus_activation_ff & ASSIGNED;         // [R5] [R12]
    end else if (sel_count) begin
      nxt_rdata = {24'h000000, `FBS_STATE_COUNT};            // [R10]
    end else if (sel_switchable) begin
      nxt_rdata = SWITCHABLE_W;                              // [R8] [R11]
    end else if (sel_active) begin
      nxt_rdata = fieldbus_active_set_ff;                    // [R9] [R7]
    end else if (sel_refused) begin
      nxt_rdata = fieldbus_refused_ff;
    end
  end

  always @(posedge i_mclk) begin
    if (i_reset) begin
      boot_ready_delay_ms_ff <= `FBS_RST_BOOT;               // [R1]
      fieldbus_activation_ff <= `FBS_RST_ACTIVATION;         // [R5]
      fieldbus_refused_ff    <= `FBS_RST_REFUSED;
    end else begin
      boot_ready_delay_ms_ff <= nxt_boot_ready_delay_ms;
      fieldbus_activation_ff <= nxt_fieldbus_activation;
      fieldbus_refused_ff    <= nxt_fieldbus_refused;
    end
  end

  // active set follows the activation word, limited to present buses
  // one cycle behind the activation word, which keeps it a plain flop
  always @(posedge i_mclk) begin
    if (i_reset) begin
      fieldbus_active_set_ff <= `FBS_RST_ACTIVATION;         // [R9]
    end else begin
      fieldbus_active_set_ff <= fieldbus_activation_ff
                                & PRESENCE_W;                // [R7] [R12]
    end
  end

  // read data stand only in the cycle after the strobe
  always @(posedge i_mclk) begin
    if (i_reset) begin
      o_rdata  <= 32'h00000000;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_rd;
      if (i_rd) begin
        o_rdata <= nxt_rdata;
      end else begin
        o_rdata <= 32'h00000000;
      end
    end
  end

  // buses are enabled only once the controller is ready
  always @(posedge i_mclk) begin
    if (i_reset) begin
      o_ready           <= 1'b0;
      o_fieldbus_enable <= 32'h00000000;
    end else begin
      o_ready <= timer_ready;                                // [R1]
      if (timer_ready) begin
        o_fieldbus_enable <= fieldbus_active_set_ff;
      end else begin
        o_fieldbus_enable <= 32'h00000000;
      end
    end
  end

  fbs_boot_timer #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_boot_timer (
    .i_mclk     (i_mclk),
    .i_reset    (i_reset),
    .i_delay_ms (boot_ready_delay_ms_ff),
    .o_ready    (timer_ready)
  );

endmodule

// ### fbs_regs_note_end.v
`timescale 1ns/1ns
// holds no logic

// ### fbs_regs_sva.sv
// port assertions for the fieldbus selection register bank
// assumes binding onto fbs_regs, one clock, sync active-high reset
`timescale 1ns/1ns
module fbs_regs_sva #(
  parameter [31:0] PRESENCE   = 32'h00040010,
  parameter [31:0] SWITCHABLE = 32'h00000000
) (
  // clock and reset
  input wire logic        i_mclk,
  input wire logic        i_reset,
  // register bus
  input wire logic [25:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        o_rvalid,
  // block state
  input wire logic        o_ready,
  input wire logic [31:0] o_fieldbus_enable
);
  localparam [31:0] ASG    = 32'h0007007f;
  localparam [25:0] A_PRES = {16'h2101, 8'h00, 2'b00};
  localparam [25:0] A_CNT  = {16'h2103, 8'h00, 2'b00};
  localparam [25:0] A_MASK = {16'h2103, 8'h01, 2'b00};
  localparam [25:0] A_ACT  = {16'h2102, 8'h00, 2'b00};

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  property p_pres_read;
    i_rd && i_addr == A_PRES |=> o_rvalid && o_rdata == (PRESENCE & ASG);
  endproperty
  a_pres_read: assert property (p_pres_read)
    else $error("presence read wrong");
  property p_cnt_read;
    i_rd && i_addr == A_CNT |=> o_rvalid && o_rdata == 32'h00000002;
  endproperty
  a_cnt_read: assert property (p_cnt_read)
    else $error("count read wrong");
  property p_mask_read;
    i_rd && i_addr == A_MASK |=> o_rdata == (SWITCHABLE & ASG);
  endproperty
  a_mask_read: assert property (p_mask_read)
    else $error("mask read wrong");
  property p_en_assigned;
    (o_fieldbus_enable & ~ASG) == 32'h0;
  endproperty
  a_en_assigned: assert property (p_en_assigned)
    else $error("unassigned enable bit set");
  property p_en_present;
    (o_fieldbus_enable & ~PRESENCE) == 32'h0;
  endproperty
  a_en_present: assert property (p_en_present)
    else $error("absent fieldbus enabled");
  property p_boot_ready;
    $fell(i_reset) |-> !o_ready ##1 !o_ready ##1 o_ready;
  endproperty
  a_boot_ready: assert property (p_boot_ready)
    else $error("ready timing wrong");
  property p_ready_hold;
    o_ready |=> o_ready;
  endproperty
  a_ready_hold: assert property (p_ready_hold)
    else $error("ready dropped");
  property p_fixed_hold;
    $past(o_ready) && o_ready |-> ((o_fieldbus_enable ^
      $past(o_fieldbus_enable)) & ~SWITCHABLE) == 32'h0;
  endproperty
  a_fixed_hold: assert property (p_fixed_hold)
    else $error("fixed fieldbus changed");
  property p_en_start;
    $rose(o_ready) |-> o_fieldbus_enable == (32'h00040010 & PRESENCE);
  endproperty
  a_en_start: assert property (p_en_start)
    else $error("start enable wrong");

  c_pres: cover property (i_rd && i_addr == A_PRES);
  c_ready: cover property ($rose(o_ready));
  c_act_wr: cover property (i_wr && i_addr == A_ACT);
endmodule

bind fbs_regs fbs_regs_sva #(
  .PRESENCE(PRESENCE),
  .SWITCHABLE(SWITCHABLE)
) u_sva (
  .i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_rvalid(o_rvalid), .o_ready(o_ready),
  .o_fieldbus_enable(o_fieldbus_enable)
);

// ### fieldbus_select_regs_tb.sv
// self-checking bench for the fieldbus selection register bank
// assumes fbs_regs with its checker bound, 20 MHz clock
`timescale 1ns/1ns
`include "fbs_consts.vh"
module fieldbus_select_regs_tb;
  // unassigned bits set in both so masking shows
  localparam [31:0] PRES = 32'hfff7fffd;
  localparam [31:0] SWM  = 32'hfff300f3;
  localparam [31:0] ASG  = 32'h0007007f;
  localparam [31:0] SW   = SWM & ASG;
  logic        i_mclk  = 1'b0;
  logic        i_reset = 1'b1;
  logic [25:0] i_addr  = 26'h0;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr    = 1'b0;
  logic        i_rd    = 1'b0;
  wire  [31:0] o_rdata;
  wire         o_rvalid;
  wire         o_ready;
  wire  [31:0] o_fieldbus_enable;
  int          fail_count = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          bl [10];
  logic [31:0] act;
  logic [31:0] refd;

  fbs_regs #(.PRESENCE(PRES), .SWITCHABLE(SWM), .CYC_PER_MS(4)) uut (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .o_ready(o_ready),
    .o_fieldbus_enable(o_fieldbus_enable));

  initial forever #25 i_mclk = ~i_mclk;

  function automatic [25:0] ad(input [15:0] x, input [7:0] s);
    ad = {x, s, 2'b00};
  endfunction

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input [31:0] e, input [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input [25:0] a, input [31:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input [25:0] a, input [31:0] e);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    chk("rvalid", 32'h1, {31'h0, o_rvalid});
    chk("rdata", e, o_rdata);
  endtask

  task automatic run_table(input [31:0] boot, input [31:0] a);
    rd(ad(`FBS_IDX_BOOT, 8'h00), boot);
    rd(ad(`FBS_IDX_PRESENCE, 8'h00), PRES & ASG);
    rd(ad(`FBS_IDX_ACTIVATION, 8'h00), a);
    rd(ad(`FBS_IDX_STATE, 8'h00), 32'h2);
    rd(ad(`FBS_IDX_STATE, 8'h01), SW);
    rd(ad(`FBS_IDX_STATE, 8'h02), a & PRES);
    rd(ad(16'h2105, 8'h00), 32'h0);
  endtask

  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fail_count++;
      close_out;
    end
  end

  initial begin
    bl = '{`FBS_BIT_USB, `FBS_BIT_RS485, `FBS_BIT_RS232, `FBS_BIT_CAN,
           `FBS_BIT_PLAIN_ETH, `FBS_BIT_RT_ETH, `FBS_BIT_SPI,
           `FBS_BIT_MODBUS_SER, `FBS_BIT_MODBUS_TCP, `FBS_BIT_IND_OBJ};
    repeat (8) @(posedge i_mclk);
    i_reset <= 1'b0;
    @(posedge i_mclk);
    #1;
    chk("ready", 32'h0, {31'h0, o_ready});
    @(posedge i_mclk);
    #1;
    chk("ready", 32'h1, {31'h0, o_ready});
    chk("enable", `FBS_RST_ACTIVATION & PRES, o_fieldbus_enable);
    run_table(32'h0, `FBS_RST_ACTIVATION);
    // read-only places and two unmapped ones must ignore writes
    wr(ad(`FBS_IDX_PRESENCE, 8'h00), 32'hffffffff);
    for (int k = 0; k < 4; k++)
      wr(ad(`FBS_IDX_STATE, k[7:0]), 32'hffffffff);
    wr(ad(16'h2105, 8'h00), 32'hffffffff);
    wr(ad(`FBS_IDX_BOOT, 8'h00), 32'h12345678);
    run_table(32'h12345678, `FBS_RST_ACTIVATION);
    act = `FBS_RST_ACTIVATION;
    refd = (32'hffffffff ^ act) & ASG & ~SW;
    wr(ad(`FBS_IDX_ACTIVATION, 8'h00), 32'hffffffff);
    act = (act & ~SW) | SW;
    run_table(32'h12345678, act);
    chk("enable", act & PRES, o_fieldbus_enable);
    rd(ad(`FBS_IDX_REFUSED, 8'h00), refd);
    wr(ad(`FBS_IDX_REFUSED, 8'h00), refd);
    rd(ad(`FBS_IDX_REFUSED, 8'h00), 32'h0);
    foreach (bl[i]) begin
      wr(ad(`FBS_IDX_ACTIVATION, 8'h00), 32'h1 << bl[i]);
      act = (act & ~SW) | ((32'h1 << bl[i]) & SW);
      rd(ad(`FBS_IDX_ACTIVATION, 8'h00), act);
      rd(ad(`FBS_IDX_STATE, 8'h02), act & PRES);
      chk("enable", act & PRES, o_fieldbus_enable);
    end
    // second reset mid-run restores defaults
    @(posedge i_mclk);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_reset <= 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
    chk("ready", 32'h1, {31'h0, o_ready});
    run_table(32'h0, `FBS_RST_ACTIVATION);
    close_out;
  end
endmodule
